/* src/sfpi_pkg.sv */
// Shared constants of the serial flash pin interface
package sfpi_pkg;

  // Byte framing on the serial lines
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned BIT_CNT_W    = 3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  DUAL_LAST    = 3'h3;
  localparam logic [2:0]  BIT_CNT_RST  = 3'h0;

  // Transmit buffer shape
  localparam int unsigned TX_FIFO_DEPTH = 4;

  // Synchroniser and pin idle levels
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic        PIN_PULLED_HI = 1'b1;
  localparam logic        CS_IDLE       = 1'b1;
  localparam logic        SCK_IDLE      = 1'b0;

  // Reset values of the shifters
  localparam logic [7:0]  RX_SHIFT_RST = 8'h00;
  localparam logic [7:0]  TX_SHIFT_RST = 8'h00;

  // Timing of the bench link clock against the block clock
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SCK_PERIOD_NS = 320;
  localparam int unsigned SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Link state encoding
  typedef enum logic [1:0] {
    LINK_IDLE   = 2'b00,
    LINK_ACTIVE = 2'b01,
    LINK_PAUSED = 2'b10
  } sfpi_link_t;

endpackage

/* src/sfpi_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sfpi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap by hand, so any depth of two or more works
  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("sfpi_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words
  logic [PTR_W-1:0] wr_ptr_q;        // Next slot to write
  logic [PTR_W-1:0] rd_ptr_q;        // Oldest slot
  logic [PTR_W:0]   count_q;         // Words held
  logic             push;            // Write accepted
  logic             pop;             // Read accepted

  // Honest flags straight from the count
  assign in_ready  = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
  end

  // Occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule

/* src/sfpi_core.sv */
// Device-side pin interface of a small serial flash: framing, shifting, pause
//
// Functional notes
// - Operations start on select fall, end on rise
// - Deselected: standby, data output tri-stated
// - Deselected: input line ignored entirely
// - Standby waits for self-timed cycle end
// - Input bits sampled on rising serial clock
// - Output bits launched on falling edges only
// - Dual read drives two bits per fall
// - Pause ignores clock, input; tri-states output
// - Pause starts only selected with clock low
// - Pause keeps all transfer state intact
// - Pause leaves self-timed cycles running
// - Write-protect low engages hardware lock
// - Floating pause and write-protect read deasserted
`timescale 1ns/100ps
module sfpi_core #(
  parameter int unsigned FIFO_DEPTH = sfpi_pkg::TX_FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Pins from the host
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       hold_n,
  input  wire logic       wp_n,
  // Two-way data lines
  input  wire logic       dual_line_0_i,
  output logic            dual_line_0_o,
  output logic            dual_line_0_oe,
  input  wire logic       dual_line_1_i,
  output logic            dual_line_1_o,
  output logic            dual_line_1_oe,
  // Received bytes toward the command decoder
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_first,
  // Bytes to send toward the host
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // Mode and status from the core
  input  wire logic       dual_mode,
  input  wire logic       busy,
  // Status toward the core
  output logic            selected,
  output logic            paused,
  output logic            standby,
  output logic            hw_lock,
  output logic            frame_start,
  output logic            frame_end
);

  // Buffer shape the logic can serve
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("sfpi_core: FIFO_DEPTH must be at least 2");
    end
  end

  // ------------------------------------------------------------------
  // Reset release through two flops
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_q;   // Release shifter
  logic       rst_int_n;    // Reset used by the rest of the block

  // Assert at once, release on the clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Bit order: cs_n, sck, hold_n, wp_n, data in
  logic [4:0] pin_meta_q;   // First stage, read only by second
  logic [4:0] pin_sync_q;   // Second stage, safe to use
  logic       cs_s;         // Synced select, active low
  logic       sck_s;        // Synced serial clock
  logic       hold_s;       // Synced pause, active low
  logic       wp_s;         // Synced write protect, active low
  logic       si_s;         // Synced input data

  // Pulled-high pins reset to their idle level, so an unwired pin
  // never reads as asserted even right after reset
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pin_meta_q <= {sfpi_pkg::CS_IDLE, sfpi_pkg::SCK_IDLE,
                     sfpi_pkg::PIN_PULLED_HI, sfpi_pkg::PIN_PULLED_HI, 1'b0};
      pin_sync_q <= {sfpi_pkg::CS_IDLE, sfpi_pkg::SCK_IDLE,
                     sfpi_pkg::PIN_PULLED_HI, sfpi_pkg::PIN_PULLED_HI, 1'b0};
    end else begin
      pin_meta_q <= {cs_n, sck, hold_n, wp_n, dual_line_0_i};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign cs_s   = pin_sync_q[4];
  assign sck_s  = pin_sync_q[3];
  assign hold_s = pin_sync_q[2];
  assign wp_s   = pin_sync_q[1];
  assign si_s   = pin_sync_q[0];

  // Line one is an output only in this mode; its input is not used
  logic unused_line1;
  assign unused_line1 = dual_line_1_i;

  // ------------------------------------------------------------------
  // Edge finders on the synced pins
  // ------------------------------------------------------------------
  logic cs_prev_q;    // Select one cycle back
  logic sck_prev_q;   // Clock one cycle back
  logic cs_fall;      // Select asserted
  logic cs_rise;      // Select released
  logic sck_rise;     // Sampling edge
  logic sck_fall;     // Launching edge

  // History tracks every cycle, even while paused, so a clock
  // transition under pause is not mistaken for an edge later
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cs_prev_q  <= sfpi_pkg::CS_IDLE;
      sck_prev_q <= sfpi_pkg::SCK_IDLE;
    end else begin
      cs_prev_q  <= cs_s;
      sck_prev_q <= sck_s;
    end
  end
  assign cs_fall  = cs_prev_q && !cs_s;
  assign cs_rise  = !cs_prev_q && cs_s;
  assign sck_rise = !sck_prev_q && sck_s;
  assign sck_fall = sck_prev_q && !sck_s;

  // ------------------------------------------------------------------
  // Link state
  // ------------------------------------------------------------------
  sfpi_pkg::sfpi_link_t link_q;   // Idle, active or paused
  logic                 shift_en; // Edges are honoured

  // A select already low out of reset reads as a fall, since the history resets to idle, and opens a frame
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      link_q <= sfpi_pkg::LINK_IDLE;
    end else begin
      unique case (link_q)
        sfpi_pkg::LINK_IDLE: begin
          if (cs_fall) begin
            link_q <= sfpi_pkg::LINK_ACTIVE;
          end
        end
        sfpi_pkg::LINK_ACTIVE: begin
          if (cs_s) begin
            link_q <= sfpi_pkg::LINK_IDLE;
          end else if (!hold_s && !sck_s) begin
            link_q <= sfpi_pkg::LINK_PAUSED;
          end
        end
        sfpi_pkg::LINK_PAUSED: begin
          // Select rising still ends the frame; release resumes it
          if (cs_s) begin
            link_q <= sfpi_pkg::LINK_IDLE;
          end else if (hold_s) begin
            link_q <= sfpi_pkg::LINK_ACTIVE;
          end
        end
        default: begin
          link_q <= sfpi_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  // Pause asserted with the clock high waits until the clock falls
  assign shift_en = (link_q == sfpi_pkg::LINK_ACTIVE) && !cs_s
                    && !(!hold_s && !sck_s);

  // ------------------------------------------------------------------
  // Receive shifter
  // ------------------------------------------------------------------
  logic [7:0] rx_shift_q;   // Bits gathered so far
  logic [2:0] rx_cnt_q;     // Bits in the current byte
  logic       rx_valid_q;   // Byte complete pulse
  logic [7:0] rx_data_q;    // Last complete byte
  logic       rx_first_q;   // Byte is the frame's first
  logic       rx_seen_q;    // A byte has been taken this frame

  // Capture only on rising edges inside an open, unpaused frame
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rx_shift_q <= sfpi_pkg::RX_SHIFT_RST;
      rx_cnt_q   <= sfpi_pkg::BIT_CNT_RST;
    end else if (cs_fall) begin
      rx_cnt_q   <= sfpi_pkg::BIT_CNT_RST;
    end else if (shift_en && sck_rise && !dual_mode) begin
      rx_shift_q <= {rx_shift_q[6:0], si_s};
      rx_cnt_q   <= rx_cnt_q + 3'h1;
    end
  end

  // Byte hand-off, most significant bit first
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rx_valid_q <= 1'b0;
      rx_data_q  <= sfpi_pkg::RX_SHIFT_RST;
      rx_first_q <= 1'b0;
      rx_seen_q  <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (cs_fall) begin
        rx_seen_q <= 1'b0;
      end else if (shift_en && sck_rise && !dual_mode
                   && rx_cnt_q == sfpi_pkg::BIT_LAST) begin
        rx_valid_q <= 1'b1;
        rx_data_q  <= {rx_shift_q[6:0], si_s};
        rx_first_q <= !rx_seen_q;
        rx_seen_q  <= 1'b1;
      end
    end
  end
  assign rx_valid = rx_valid_q;
  assign rx_data  = rx_data_q;
  assign rx_first = rx_first_q;

  // ------------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------------
  logic       fifo_valid;   // Byte waiting to go out
  logic       fifo_pop;     // Shifter takes it
  logic [7:0] fifo_data;    // Waiting byte

  // Depth buys slack for the decoder; a full buffer stalls it via tx_ready
  sfpi_fifo #(
    .WIDTH (sfpi_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_int_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ------------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------------
  logic [7:0] tx_shift_q;   // Bits still to launch
  logic [2:0] tx_cnt_q;     // Launches still to come in the byte
  logic       tx_busy_q;    // A byte is being launched
  logic       tx_drive_q;   // Output phase of the frame reached
  logic       dual_q;       // Output phase uses both lines
  logic       line0_q;      // Level on line zero
  logic       line1_q;      // Level on line one
  logic       tx_last;      // Current fall follows the byte's last bit
  logic       tx_load;      // Current fall starts a new byte

  // A byte is loaded only at a falling edge, so a mode-3 frame whose
  // first edge is a fall launches nothing before data exists
  assign tx_last  = tx_busy_q && tx_cnt_q == sfpi_pkg::BIT_CNT_RST;
  assign tx_load  = shift_en && sck_fall && fifo_valid
                    && (!tx_busy_q || tx_last);
  assign fifo_pop = tx_load;

  // Launch: single mode one bit, dual mode two bits, per fall
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tx_shift_q <= sfpi_pkg::TX_SHIFT_RST;
      tx_cnt_q   <= sfpi_pkg::BIT_CNT_RST;
      tx_busy_q  <= 1'b0;
      line0_q    <= 1'b0;
      line1_q    <= 1'b0;
    end else if (!selected) begin
      tx_busy_q  <= 1'b0;
      tx_cnt_q   <= sfpi_pkg::BIT_CNT_RST;
    end else if (tx_load) begin
      if (dual_mode) begin
        line1_q    <= fifo_data[7];
        line0_q    <= fifo_data[6];
        tx_shift_q <= {fifo_data[5:0], 2'b00};
        tx_cnt_q   <= sfpi_pkg::DUAL_LAST;
      end else begin
        line1_q    <= fifo_data[7];
        tx_shift_q <= {fifo_data[6:0], 1'b0};
        tx_cnt_q   <= sfpi_pkg::BIT_LAST;
      end
      tx_busy_q <= 1'b1;
    end else if (shift_en && sck_fall && tx_busy_q) begin
      if (tx_last) begin
        // Buffer ran dry: hold the last level until more arrives
        tx_busy_q <= 1'b0;
      end else if (dual_q) begin
        line1_q    <= tx_shift_q[7];
        line0_q    <= tx_shift_q[6];
        tx_shift_q <= {tx_shift_q[5:0], 2'b00};
        tx_cnt_q   <= tx_cnt_q - 3'h1;
      end else begin
        line1_q    <= tx_shift_q[7];
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        tx_cnt_q   <= tx_cnt_q - 3'h1;
      end
    end
  end

  // Output phase and line zero direction, both dropped at deselect
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tx_drive_q <= 1'b0;
      dual_q     <= 1'b0;
    end else if (!selected) begin
      tx_drive_q <= 1'b0;
      dual_q     <= 1'b0;
    end else if (tx_load) begin
      tx_drive_q <= 1'b1;
      dual_q     <= dual_mode;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Enables follow state flops; pause or deselect float the lines
  assign dual_line_1_o  = line1_q;
  assign dual_line_1_oe = selected && !paused && tx_drive_q;
  assign dual_line_0_o  = line0_q;
  assign dual_line_0_oe = selected && !paused && tx_drive_q && dual_q;

  // ------------------------------------------------------------------
  // Status toward the core
  // ------------------------------------------------------------------
  logic busy_q;   // Self-timed cycle running, registered

  // The busy level comes from the array logic on this clock
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
    end
  end

  assign selected    = (link_q != sfpi_pkg::LINK_IDLE);
  assign paused      = (link_q == sfpi_pkg::LINK_PAUSED);
  // Pause never gates standby or busy: only the serial side stops
  assign standby     = !selected && !busy_q;
  assign hw_lock     = !wp_s;
  assign frame_start = (link_q == sfpi_pkg::LINK_IDLE) && cs_fall;
  assign frame_end   = selected && cs_rise;

endmodule

/* verif/sfpi_checker.sv */
// Assertion checker for the flash pin interface top
`timescale 1ns/100ps
module sfpi_checker #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic dual_line_0_oe,
  input wire logic dual_line_1_o,
  input wire logic dual_line_1_oe,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic dual_mode,
  input wire logic busy,
  input wire logic selected,
  input wire logic paused,
  input wire logic standby,
  input wire logic hw_lock,
  input wire logic frame_start,
  input wire logic frame_end
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Select high long enough to pass the synchroniser
  sequence desel_s;
    cs_n [*5];
  endsequence
  // Pause pin low while selected with the clock parked low
  sequence hold_s;
    (!hold_n && !cs_n && !sck) [*5];
  endsequence

  desel_tristate_a: assert property (desel_s |-> !dual_line_1_oe && !dual_line_0_oe)
    else $error("data line driven while deselected");
  desel_quiet_a: assert property (desel_s |-> !rx_valid)
    else $error("byte received while deselected");
  busy_standby_a: assert property (busy [*2] |-> !standby)
    else $error("standby during self-timed cycle");
  idle_standby_a: assert property ((cs_n && !busy) [*6] |-> standby)
    else $error("no standby while idle");
  launch_fall_a: assert property (selected && $changed(dual_line_1_o) |-> !$past(sck, 3))
    else $error("output changed away from a falling edge");
  dual_no_rx_a: assert property (dual_mode [*8] |-> !rx_valid)
    else $error("byte received in dual mode");
  pause_float_a: assert property (paused |-> !dual_line_1_oe && !dual_line_0_oe)
    else $error("data line driven while paused");
  hold_enter_a: assert property (hold_s |-> paused)
    else $error("pause not entered");
  pause_keeps_a: assert property (((!cs_n) [*3] ##0 paused) |=> selected)
    else $error("pause dropped the frame");
  lock_on_a: assert property (!wp_n [*4] |-> hw_lock)
    else $error("lock not engaged");
  lock_off_a: assert property (wp_n [*4] |-> !hw_lock)
    else $error("lock engaged with pin high");
  start_open_a: assert property (frame_start |=> selected)
    else $error("frame not opened");
  end_close_a: assert property (frame_end |-> ##[0:2] !selected)
    else $error("frame not closed");
  first_flag_a: assert property ($rose(rx_first) |-> rx_valid)
    else $error("first flag without byte");
endmodule

bind sfpi_core sfpi_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .ref_clk, .rst_n, .cs_n, .sck, .hold_n, .wp_n, .dual_line_0_oe, .dual_line_1_o,
  .dual_line_1_oe, .rx_valid, .rx_first, .dual_mode, .busy, .selected, .paused,
  .standby, .hw_lock, .frame_start, .frame_end);

/* verif/sfpi_host.sv */
// Host controller model driving select, clock, data and pause
`timescale 1ns/100ps
module sfpi_host (
  input  wire logic ref_clk,
  input  wire logic line_0,
  input  wire logic line_1,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      si_en,
  output logic      hold_n
);
  logic idle_hi; // Clock idle level, high for mode 3

  // Pins parked idle, pause pin at its pulled level
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    si_en = 1'b1;
    hold_n = 1'b1;
    idle_hi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Park the clock first, then select
  task automatic open_frame(input logic hi);
    idle_hi = hi;
    sck <= hi;
    si_en <= 1'b1;
    tick(4);
    cs_n <= 1'b0;
    tick(4);
  endtask

  // Clock back to idle before deselecting
  task automatic close_frame();
    sck <= idle_hi;
    tick(4);
    cs_n <= 1'b1;
    tick(8);
  endtask

  // Bit cycles: data set while low; read late in the high phase, since
  // the device answers several block clocks after each fall
  task automatic xfer(input logic [7:0] d, input int nb, input logic dual,
                      input int hold_at, output logic [7:0] q);
    q = 8'h00;
    si_en <= ~dual;
    for (int i = 0; i < nb; i++) begin
      sck <= 1'b0;
      si <= d[7-i];
      tick(4);
      // Pause only with clock low; noise on clock and data meanwhile
      if (i == hold_at) begin
        hold_n <= 1'b0;
        tick(6);
        sck <= 1'b1;
        si <= ~d[7-i];
        tick(4);
        sck <= 1'b0;
        si <= d[7-i];
        tick(4);
        hold_n <= 1'b1;
        tick(4);
      end
      sck <= 1'b1;
      tick(3);
      q = dual ? {q[5:0], line_1, line_0} : {q[6:0], line_1};
      tick(1);
    end
  endtask
endmodule

/* verif/sfpi_core_tb.sv */
// Self-checking bench for the flash pin interface
`timescale 1ns/100ps
module sfpi_core_tb;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp_n = 1'b1;      // Protect pin at pulled level
  logic       tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       dual_mode = 1'b0;
  logic       busy = 1'b0;
  logic       pat = 1'b0;       // Floating wire stand-in
  logic       cs_n, sck, hold_n, si, si_en, line_0, line_1;
  logic       o0, oe0, o1, oe1, rx_valid, rx_first, tx_ready;
  logic       selected, paused, standby, hw_lock;
  logic [7:0] rx_data, q, cmd;
  logic [8:0] exp_rx[$];        // Expected {first, byte}
  logic [7:0] exp_tx[$];        // Bytes the host should read
  int         fail_count = 0;
  int         num_checks = 0;

  always #20 ref_clk = ~ref_clk;
  // Undriven wires flip every cycle, never a stale level
  always @(posedge ref_clk) pat <= ~pat;
  assign line_0 = oe0 ? o0 : (si_en ? si : pat);
  assign line_1 = oe1 ? o1 : pat;

  sfpi_host host (.ref_clk, .line_0, .line_1, .cs_n, .sck, .si, .si_en, .hold_n);
  sfpi_core #(.FIFO_DEPTH(sfpi_pkg::TX_FIFO_DEPTH)) uut (
    .ref_clk, .rst_n, .cs_n, .sck, .hold_n, .wp_n,
    .dual_line_0_i(line_0), .dual_line_0_o(o0), .dual_line_0_oe(oe0),
    .dual_line_1_i(line_1), .dual_line_1_o(o1), .dual_line_1_oe(oe1),
    .rx_valid, .rx_data, .rx_first, .tx_valid, .tx_ready, .tx_data,
    .dual_mode, .busy, .selected, .paused, .standby, .hw_lock,
    .frame_start(), .frame_end());

  task automatic chk_byte(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Oldest expected byte against each received one
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_rx.size() == 0) chk_bit("rx_spurious", 1'b0, 1'b1);
      else chk_byte("rx_byte", exp_rx.pop_front(), {rx_first, rx_data});
    end
  end

  // Offer one byte; valid stays up so pushes run back to back
  task automatic push(input logic [7:0] d);
    int i;
    tx_valid <= 1'b1;
    tx_data <= d;
    exp_tx.push_back(d);
    @(negedge ref_clk);
    for (i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge ref_clk);
    if (i == 50) chk_bit("push_wait", 1'b1, 1'b0);
    @(posedge ref_clk);
  endtask

  // Whole frame of random bytes; host reads are compared when bytes were queued
  task automatic run_frame(input logic hi, input int nb, input int hold_at, input logic dual);
    logic [7:0] d;
    host.open_frame(hi);
    for (int i = 0; i < nb; i++) begin
      d = 8'($urandom);
      if (!dual) exp_rx.push_back({i == 0, d});
      host.xfer(d, dual ? 4 : 8, dual, i == 0 ? hold_at : -1, q);
      if (exp_tx.size() > 0) chk_byte("tx_byte", {1'b0, exp_tx.pop_front()}, {1'b0, q});
    end
    host.close_frame();
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h7fd4_cea3));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_bit("standby", 1'b1, standby);
    chk_bit("line1_oe", 1'b0, oe1);
    chk_bit("line0_oe", 1'b0, oe0);
    chk_bit("hw_lock", 1'b0, hw_lock);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      wp_n <= 1'($urandom);
      repeat (5) @(posedge ref_clk);
      chk_bit("hw_lock", ~wp_n, hw_lock);
    end
    wp_n <= 1'b1;
    $display("write protect done");
    for (int m = 0; m < 2; m++) run_frame(m[0], 3, -1, 1'b0);
    $display("receive both idle levels done");
    // Partial byte dropped, next frame restarts the count
    host.open_frame(1'b0);
    host.xfer(8'($urandom), 4, 1'b0, -1, q);
    host.close_frame();
    run_frame(1'b0, 1, -1, 1'b0);
    host.xfer(8'($urandom), 8, 1'b0, -1, q);
    host.close_frame();
    $display("framing and deselect done");
    busy <= 1'b1;
    run_frame(1'b0, 2, 4, 1'b0);
    chk_bit("standby", 1'b0, standby);
    busy <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk_bit("standby", 1'b1, standby);
    $display("pause and busy done");
    for (int i = 0; i < sfpi_pkg::TX_FIFO_DEPTH; i++) push(8'($urandom));
    tx_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_bit("tx_ready", 1'b0, tx_ready);
    run_frame(1'b1, 4, -1, 1'b0);
    chk_bit("tx_ready", 1'b1, tx_ready);
    $display("buffered transmit done");
    // Mode 0 read: command byte first, reply launched from the fall after it
    cmd = 8'($urandom);
    exp_rx.push_back({1'b1, cmd});
    host.open_frame(1'b0);
    host.xfer(cmd, 8, 1'b0, -1, q);
    push(8'($urandom));
    tx_valid <= 1'b0;
    cmd = 8'($urandom);
    exp_rx.push_back({1'b0, cmd});
    host.xfer(cmd, 8, 1'b0, -1, q);
    chk_byte("tx_mode0", {1'b0, exp_tx.pop_front()}, {1'b0, q});
    host.close_frame();
    $display("mode 0 read done");
    dual_mode <= 1'b1;
    push(8'($urandom));
    tx_valid <= 1'b0;
    run_frame(1'b1, 1, -1, 1'b1);
    dual_mode <= 1'b0;
    chk_bit("line0_oe", 1'b0, oe0);
    $display("dual read done");
    for (int i = 0; i < 100 && exp_rx.size() > 0; i++) @(posedge ref_clk);
    if (exp_rx.size() > 0) chk_bit("rx_drain", 1'b1, 1'b0);
    conclude();
  end
endmodule
